// file: scrx_params.svh
// register offsets, reset values, field positions and timing counts
`ifndef SCRX_PARAMS_SVH
`define SCRX_PARAMS_SVH
`define SCRX_A_STAT     16'hfe08
`define SCRX_A_CHAR     16'hfe12
`define SCRX_A_IRQ      16'hfe09
`define SCRX_A_MASK     16'hfe0a
`define SCRX_CHAR_RST   8'h2c
`define SCRX_CRC_INIT   16'hffff
`define SCRX_CRC_POLY   16'h1021
`define SCRX_CRC_GOOD   16'h1d0f
`define SCRX_LRC_GOOD   8'h00
`define SCRX_TS_DIR     8'h3b
`define SCRX_TS_INV     8'h03
`define SCRX_H_PAR      5'd19
`define SCRX_H_BRK      5'd21
`define SCRX_H_CARDBRK  5'd22
`define SCRX_H_FIRST    5'd3
`define SCRX_SYNC_EDGE  4'd9
`define SCRX_B_LAST     5
`define SCRX_B_CDIS     7
`define SCRX_B_DETECT_INITIAL_CHARACTER    6
`define SCRX_B_CONV     5
`define SCRX_B_RSV      2
`define SCRX_I_PAR      0
`define SCRX_I_OVR      1
`define SCRX_I_CRC      2
`endif

// file: scrx_pkg.sv
// types of the smart card receive status and character control block
`default_nettype none
package scrx_pkg;
    typedef enum logic [1:0] {SCRX_IDLE, SCRX_CHAR, SCRX_BRK} scrx_state_t;
    typedef struct packed {
        logic        io_s1;
        logic        io_s2;
        logic        io_prev;
        logic        ck_s1;
        logic        ck_s2;
        logic        ck_prev;
        scrx_state_t st;
        logic [4:0]  h;
        logic [8:0]  raw;
        logic        err_pend;
        logic        tx_on;
        logic [4:0]  tx_h;
        logic [3:0]  edges;
        logic        ninth;
        logic        last;
        logic        cerr;
        logic        ovr;
        logic        par;
        logic        cdis;
        logic        detect_initial_character;
        logic        conv;
        logic [1:0]  break_length_select;
        logic        rsv;
        logic [15:0] crc;
        logic [7:0]  lrc;
        logic [2:0]  irq_st;
        logic [2:0]  irq_mask;
        logic        irq;
        logic [7:0]  rdata;
        logic        io_oe;
        logic        io_out;
        logic [7:0]  rx_data;
        logic        rx_wr;
        logic        card_brk;
    } scrx_reg_t;
endpackage : scrx_pkg
`default_nettype wire

// file: scrx_top.sv
// receive status, initial character and error break logic of the card port
// What this block does
// [R1] sync nine-bit mode: ninth clock edge data captured
// [R2] last byte: check CRC residue or LRC
// [R3] read-only checksum error bit
// [R4] read-only receive FIFO full bit
// [R5] FIFO empty bit, never an interrupt
// [R6] byte while full sets overrun, clear-on-read, interrupt
// [R7] bytes discarded while overrun stands
// [R8] parity error flag, clear-on-read, interrupt
// [R9] error break starts 10.5 ETU after start
// [R10] card break sampled 11 ETU after our start
// [R11] armed detection treats next character as TS
// [R12] unarmed detection keeps current convention
// [R13] TS obeys parity disable and break enable
// [R14] TS decoded ahead of FIFO, still stored
// [R15] convention bit set by TS, firmware writable
// [R16] firmware rewrites convention bit per card
// [R17] break length 1, 1.5 or 2 ETU
// [R18] inverse data converted unless disabled
// [R19] no error break outside T=0
`include "scrx_params.svh"
`default_nettype none
module scrx_top
    import scrx_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic [15:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    output logic             IRQ_O,
    input  wire logic        CARD_IO_I,
    output logic             CARD_IO_O,
    output logic             CARD_IO_OE_O,
    input  wire logic        CARD_CLK_I,
    input  wire logic        HALF_ETU_I,
    input  wire logic        T0_MODE_I,
    input  wire logic        SYNC_MODE_I,
    input  wire logic        NINE_BIT_FORMAT_SELECT_I,
    input  wire logic        PARITY_CHECK_DISABLE_I,
    input  wire logic        BREAK_GENERATE_ENABLE_I,
    input  wire logic        CRC_SELECT_I,
    input  wire logic        TX_START_I,
    input  wire logic        RX_FIFO_FULL_I,
    input  wire logic        RX_FIFO_EMPTY_I,
    output logic      [7:0]  RX_DATA_O,
    output logic             RX_WR_O,
    output logic             CARD_BREAK_O
);

    // ==========================================================
    // helpers
    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction : rev8

    // ccitt polynomial, msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `SCRX_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte

    // break length in half-ETU ticks; reserved code falls back to 1 ETU
    function automatic logic [4:0] brk_len(input logic [1:0] sel);
        logic [4:0] r;
        unique case (sel)
            2'b01:   r = 5'd3;
            2'b10:   r = 5'd4;
            default: r = 5'd2;
        endcase
        return r;
    endfunction : brk_len

    // initial character decode: bit 1 = known pattern, bit 0 = direct
    function automatic logic [1:0] ts_decode(input logic [7:0] d);
        logic [1:0] r;
        r = 2'b00;
        if (d == `SCRX_TS_DIR) begin
            r = 2'b11;
        end else if (d == `SCRX_TS_INV) begin
            r = 2'b10;
        end
        return r;
    endfunction : ts_decode

    // data and parity sample points, odd half ticks only
    // mid-bit sampling leaves half an etu of slack for sync delay
    function automatic logic is_sample(input logic [4:0] t);
        logic r;
        r = t[0] && (t >= `SCRX_H_FIRST) && (t <= `SCRX_H_PAR);
        return r;
    endfunction : is_sample

    // end-of-block check: residue or lrc must reach its good value
    function automatic logic sum_bad(input logic use_crc, input logic [15:0] c, input logic [7:0] l);
        logic r;
        r = use_crc ? (c != `SCRX_CRC_GOOD) : (l != `SCRX_LRC_GOOD);
        return r;
    endfunction : sum_bad

    // status byte; fifo bits are live, so they are never stale
    function automatic logic [7:0] stat_word(input scrx_reg_t s, input logic full, input logic empty);
        logic [7:0] r;
        r = {s.ninth, 1'b0, s.last, s.cerr, full, empty, s.ovr, s.par};
        return r;
    endfunction : stat_word

    // ==========================================================
    // state
    scrx_reg_t q;
    scrx_reg_t next_q;

    localparam logic [7:0] char_rst = `SCRX_CHAR_RST;

    logic [8:0]  full9;
    logic [7:0]  d_raw;
    logic [7:0]  d_out;
    logic        eff_conv;
    logic        perr;
    logic [4:0]  nh;
    logic [15:0] crc_n;
    logic [7:0]  lrc_n;
    logic        stat_rd;
    logic [1:0]  ts_code;

    // ==========================================================
    // next state
    always_comb begin
        next_q = q;
        next_q.rx_wr = 1'b0;
        next_q.card_brk = 1'b0;
        next_q.io_out = 1'b0;
        // two-flop synchronisers, edges judged on the second flop only
        next_q.io_s1 = CARD_IO_I;
        next_q.io_s2 = q.io_s1;
        next_q.io_prev = q.io_s2;
        next_q.ck_s1 = CARD_CLK_I;
        next_q.ck_s2 = q.ck_s1;
        next_q.ck_prev = q.ck_s2;
        nh = q.h + 5'd1;
        full9 = {q.io_s2, q.raw[8:1]};
        d_raw = full9[7:0];
        eff_conv = q.conv;
        ts_code = ts_decode(d_raw);
        // unknown first character keeps the current convention
        if (q.detect_initial_character && ts_code[1]) begin
            eff_conv = ts_code[0]; // R11
        end
        // even parity on the line; inverse flips the sense
        perr = !PARITY_CHECK_DISABLE_I && ((^full9) == eff_conv); // R13
        d_out = (eff_conv || q.cdis) ? d_raw : ~rev8(d_raw); // R18
        crc_n = crc_byte(q.crc, d_out);
        lrc_n = q.lrc ^ d_out;
        stat_rd = RD_I && (ADDR_I == `SCRX_A_STAT);

        // ------------------------------------------------------
        // register writes; hardware events below win a same-cycle clash
        if (WR_I) begin
            unique case (ADDR_I)
                `SCRX_A_STAT: begin
                    next_q.last = WDATA_I[`SCRX_B_LAST];
                    if (WDATA_I[`SCRX_B_LAST]) begin
                        next_q.cerr = 1'b0;
                    end
                end
                `SCRX_A_CHAR: begin
                    next_q.cdis = WDATA_I[`SCRX_B_CDIS];
                    next_q.detect_initial_character = WDATA_I[`SCRX_B_DETECT_INITIAL_CHARACTER];
                    next_q.conv = WDATA_I[`SCRX_B_CONV]; // R15 R16
                    next_q.break_length_select = WDATA_I[4:3];
                    next_q.rsv = WDATA_I[`SCRX_B_RSV];
                end
                `SCRX_A_IRQ: next_q.irq_st = q.irq_st & ~WDATA_I[2:0];
                `SCRX_A_MASK: next_q.irq_mask = WDATA_I[2:0];
                default: ;
            endcase
        end
        if (stat_rd) begin
            next_q.par = 1'b0; // R8
            next_q.ovr = 1'b0; // R6
        end

        // ------------------------------------------------------
        // synchronous nine-bit capture
        if (!(SYNC_MODE_I && NINE_BIT_FORMAT_SELECT_I)) begin
            next_q.edges = '0;
        end else if (q.ck_s2 && !q.ck_prev) begin
            if (q.edges == `SCRX_SYNC_EDGE - 4'd1) begin
                next_q.ninth = q.io_s2; // R1
                next_q.edges = '0;
            end else begin
                next_q.edges = q.edges + 4'd1;
            end
        end

        // ------------------------------------------------------
        // card break after our own transmitted character
        // line is read through the synchroniser, two clocks late
        if (TX_START_I) begin
            next_q.tx_on = 1'b1;
            next_q.tx_h = '0;
        end else if (q.tx_on && HALF_ETU_I) begin
            next_q.tx_h = q.tx_h + 5'd1;
            if (q.tx_h + 5'd1 == `SCRX_H_CARDBRK) begin
                next_q.card_brk = !q.io_s2; // R10
                next_q.tx_on = 1'b0;
            end
        end

        // ------------------------------------------------------
        // character receiver, timed in half-ETU ticks from start edge
        // a running transmit check blocks starts: our echo is no character
        unique case (q.st)
            SCRX_IDLE: begin
                if (!SYNC_MODE_I && !q.tx_on && q.io_prev && !q.io_s2) begin
                    next_q.st = SCRX_CHAR;
                    next_q.h = '0;
                    next_q.err_pend = 1'b0;
                end
            end
            SCRX_CHAR: begin
                if (HALF_ETU_I) begin
                    next_q.h = nh;
                    if (is_sample(nh)) begin
                        next_q.raw = full9;
                    end
                    if (nh == `SCRX_H_PAR) begin
                        if (q.detect_initial_character) begin
                            next_q.detect_initial_character = 1'b0; // R11
                            next_q.conv = eff_conv; // R12 R15
                        end
                        if (perr) begin
                            next_q.par = 1'b1; // R8
                            next_q.irq_st[`SCRX_I_PAR] = 1'b1; // R8
                            next_q.err_pend = T0_MODE_I; // R19
                        end
                        if (RX_FIFO_FULL_I || q.ovr) begin
                            if (RX_FIFO_FULL_I) begin
                                next_q.ovr = 1'b1; // R6
                                next_q.irq_st[`SCRX_I_OVR] = 1'b1; // R6
                            end
                        end else begin
                            next_q.rx_wr = 1'b1; // R7 R14
                            next_q.rx_data = d_out; // R14
                        end
                        next_q.crc = crc_n;
                        next_q.lrc = lrc_n;
                        if (q.last) begin
                            if (sum_bad(CRC_SELECT_I, crc_n, lrc_n)) begin
                                next_q.cerr = 1'b1; // R2 R3
                                next_q.irq_st[`SCRX_I_CRC] = 1'b1;
                            end
                            next_q.last = 1'b0; // R2
                            next_q.crc = `SCRX_CRC_INIT;
                            next_q.lrc = `SCRX_LRC_GOOD;
                        end
                    end
                    if (nh == `SCRX_H_BRK) begin
                        if (q.err_pend && BREAK_GENERATE_ENABLE_I) begin
                            next_q.st = SCRX_BRK; // R9 R13
                            next_q.io_oe = 1'b1; // R9
                            next_q.h = '0;
                        end else begin
                            next_q.st = SCRX_IDLE;
                        end
                    end
                end
            end
            SCRX_BRK: begin
                if (HALF_ETU_I) begin
                    next_q.h = nh;
                    if (nh == brk_len(q.break_length_select)) begin
                        next_q.io_oe = 1'b0; // R17
                        next_q.st = SCRX_IDLE;
                    end
                end
            end
        endcase

        // ------------------------------------------------------
        // bus read data and interrupt
        next_q.rdata = 8'h00;
        if (RD_I) begin
            unique case (ADDR_I)
                `SCRX_A_STAT: next_q.rdata = stat_word(q, RX_FIFO_FULL_I, RX_FIFO_EMPTY_I); // R3 R4 R5
                `SCRX_A_CHAR: next_q.rdata = {q.cdis, q.detect_initial_character, q.conv, q.break_length_select,
                                              q.rsv, 2'b00};
                `SCRX_A_IRQ:  next_q.rdata = {5'b00000, q.irq_st};
                `SCRX_A_MASK: next_q.rdata = {5'b00000, q.irq_mask};
                default:      next_q.rdata = 8'h00;
            endcase
        end
        // empty has no interrupt status bit here, so it can never interrupt
        next_q.irq = |(next_q.irq_st & next_q.irq_mask); // R5
    end

    // ==========================================================
    // registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            q <= '0;
            // idle line level, so no false start follows reset
            q.io_s1 <= 1'b1;
            q.io_s2 <= 1'b1;
            q.io_prev <= 1'b1;
            q.st <= SCRX_IDLE;
            q.cdis <= char_rst[`SCRX_B_CDIS];
            q.detect_initial_character <= char_rst[`SCRX_B_DETECT_INITIAL_CHARACTER];
            q.conv <= char_rst[`SCRX_B_CONV];
            q.break_length_select <= char_rst[4:3];
            q.rsv <= char_rst[`SCRX_B_RSV];
            q.crc <= `SCRX_CRC_INIT;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // outputs
    assign RDATA_O = q.rdata;
    assign IRQ_O = q.irq;
    assign CARD_IO_O = q.io_out;
    assign CARD_IO_OE_O = q.io_oe;
    assign RX_DATA_O = q.rx_data;
    assign RX_WR_O = q.rx_wr;
    assign CARD_BREAK_O = q.card_brk;

endmodule : scrx_top
`default_nettype wire

// file: scrx_chk.sv
// port-level assertions of the card receive status block
`include "scrx_params.svh"
`default_nettype none
module scrx_chk (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [15:0] ADDR_I,
    input wire logic        RD_I,
    input wire logic [7:0]  RDATA_O,
    input wire logic        CARD_IO_I,
    input wire logic        CARD_IO_OE_O,
    input wire logic        HALF_ETU_I,
    input wire logic        T0_MODE_I,
    input wire logic        BREAK_GENERATE_ENABLE_I,
    input wire logic        RX_FIFO_FULL_I,
    input wire logic        RX_FIFO_EMPTY_I,
    input wire logic        RX_WR_O,
    input wire logic        CARD_BREAK_O
);
    // ==========
    // half etu ticks seen while the break is driven
    logic [2:0] oe_ticks;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            oe_ticks <= 3'h0;
        end else begin
            oe_ticks <= CARD_IO_OE_O ? oe_ticks + 3'(HALF_ETU_I) : 3'h0;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ==========
    // properties
    sequence s_stat_read;
        RD_I && ADDR_I == `SCRX_A_STAT;
    endsequence
    sequence s_pulse_end;
        ##1 !CARD_BREAK_O;
    endsequence
    property p_empty_live;
        s_stat_read |=> RDATA_O[2] == $past(RX_FIFO_EMPTY_I);
    endproperty
    a_empty_live: assert property (p_empty_live) else $error("empty bit wrong");
    property p_full_live;
        s_stat_read |=> RDATA_O[3] == $past(RX_FIFO_FULL_I);
    endproperty
    a_full_live: assert property (p_full_live) else $error("full bit wrong");
    property p_brk_gate;
        $rose(CARD_IO_OE_O) |-> T0_MODE_I && BREAK_GENERATE_ENABLE_I;
    endproperty
    a_brk_gate: assert property (p_brk_gate) else $error("break outside t0 or disabled");
    property p_brk_tick;
        $rose(CARD_IO_OE_O) |-> $past(HALF_ETU_I);
    endproperty
    a_brk_tick: assert property (p_brk_tick) else $error("break not on half etu");
    property p_brk_len;
        $fell(CARD_IO_OE_O) |-> oe_ticks inside {[2:4]};
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break length out of range");
    property p_no_wr_full;
        RX_WR_O |-> !$past(RX_FIFO_FULL_I);
    endproperty
    a_no_wr_full: assert property (p_no_wr_full) else $error("byte written while full");
    property p_wr_single;
        RX_WR_O |=> !RX_WR_O [*8];
    endproperty
    a_wr_single: assert property (p_wr_single) else $error("byte stored twice");
    property p_card_brk;
        CARD_BREAK_O |-> !$past(CARD_IO_I, 4) ##0 s_pulse_end;
    endproperty
    a_card_brk: assert property (p_card_brk) else $error("card break without low line");
endmodule : scrx_chk
bind scrx_top scrx_chk i_chk (.*);
`default_nettype wire

// file: scrx_card.sv
// card side model: characters, break after our character, sync clocking
`default_nettype none
module scrx_card (
    input  wire logic clk_i,
    input  wire logic half_i,
    output logic      io_o,
    output logic      ck_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // released line sits at the pull-up level; clock rests low
    initial begin
        io_o = 1'b1;
        ck_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i iff half_i);
    endtask : tick
    // ==========
    // even parity; bad flips it
    task automatic send(input logic [7:0] d, input logic bad);
        logic [9:0] f;
        f = {^d ^ bad, d, 1'b0};
        tick(1);
        for (int i = 0; i < 10; i++) begin
            io_o <= f[i];
            tick(2);
        end
        io_o <= 1'b1;
        tick(16);
    endtask : send
    // low well around the 22nd tick, sync delay has slack
    task automatic brk;
        tick(19);
        io_o <= 1'b0;
        tick(6);
        io_o <= 1'b1;
    endtask : brk
    // nine clock pulses at 160 ns, line set before the last
    task automatic sync9(input logic b);
        for (int i = 1; i <= 9; i++) begin
            if (i == 9) io_o <= b;
            repeat (4) @(posedge clk_i);
            ck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            ck_o <= 1'b0;
        end
        io_o <= 1'b1;
    endtask : sync9
endmodule : scrx_card
`default_nettype wire

// file: smart_card_rx_status_and_ts_control_tb.sv
// self-checking bench of the card receive status block
`include "scrx_params.svh"
`default_nettype none
module smart_card_rx_status_and_ts_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, wr, rd, half, t0, sync, pdis, bgen, crcs, txs, full, empty;
    logic        card_io, card_ck, irq, io_o, io_oe, rx_wr, cbrk, rd_p;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, rxd;
    logic [2:0]  div;
    logic [7:0]  q_rd[$], q_rx[$], q_oe[$];
    int          err_count, checked, oe_n;
    wire logic   line = card_io & ~(io_oe & ~io_o);
    scrx_top i_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .IRQ_O(irq), .CARD_IO_I(line), .CARD_IO_O(io_o), .CARD_IO_OE_O(io_oe),
        .CARD_CLK_I(card_ck), .HALF_ETU_I(half), .T0_MODE_I(t0), .SYNC_MODE_I(sync),
        .NINE_BIT_FORMAT_SELECT_I(sync), .PARITY_CHECK_DISABLE_I(pdis), .BREAK_GENERATE_ENABLE_I(bgen),
        .CRC_SELECT_I(crcs), .TX_START_I(txs), .RX_FIFO_FULL_I(full), .RX_FIFO_EMPTY_I(empty),
        .RX_DATA_O(rxd), .RX_WR_O(rx_wr), .CARD_BREAK_O(cbrk));
    scrx_card i_card (.clk_i(clk), .half_i(half), .io_o(card_io), .ck_o(card_ck));
    // ==========
    // clock, half etu divider, watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        div <= div + 3'h1;
        half <= (div == 3'h7);
        rd_p <= rd;
    end
    initial begin
        #1ms;
        err_count++;
        conclude();
    end
    // ==========
    // tasks
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        q_rd.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    task automatic rx(input logic [7:0] d, input logic bad, input logic keep, input logic [7:0] e);
        if (keep) q_rx.push_back(e);
        i_card.send(d, bad);
    endtask : rx
    task automatic conclude;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // ==========
    // monitor: oldest note against each result
    always @(negedge clk) begin
        if (rd_p) cmp("rdata", q_rd.size() ? q_rd.pop_front() : 8'hxx, rdata);
        if (rx_wr) cmp("rx_data", q_rx.size() ? q_rx.pop_front() : 8'hxx, rxd);
        if (io_oe) oe_n++;
        else if (oe_n > 0) begin
            cmp("break_len", q_oe.size() ? q_oe.pop_front() : 8'hxx, 8'((oe_n + 4) / 8));
            oe_n = 0;
        end
    end
    // ==========
    // main sequence
    initial begin
        logic [7:0] d, e;
        int n;
        {rst, empty} = 2'b11;
        {wr, rd, half, t0, sync, pdis, bgen, crcs, txs, full, rd_p} = '0;
        {addr, wdata, div, err_count, checked, oe_n} = '0;
        n = $urandom(59);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`SCRX_A_STAT, 8'h04);
        rd_reg(`SCRX_A_CHAR, `SCRX_CHAR_RST);
        rd_reg(`SCRX_A_IRQ, 8'h00);
        rd_reg(16'h0000, 8'h00);
        empty <= 1'b0;
        wr_reg(`SCRX_A_MASK, 8'h07);
        d = 8'($urandom_range(1, 255));
        wr_reg(`SCRX_A_STAT, 8'h20);
        rx(d, 1'b0, 1'b1, d);
        rd_reg(`SCRX_A_STAT, 8'h10);
        rd_reg(`SCRX_A_IRQ, 8'h04);
        cmp("irq", 8'h01, {7'h0, irq});
        wr_reg(`SCRX_A_IRQ, 8'h04);
        rx(d, 1'b0, 1'b1, d);
        wr_reg(`SCRX_A_STAT, 8'h20);
        rx(d, 1'b0, 1'b1, d);
        rd_reg(`SCRX_A_STAT, 8'h00);
        cmp("irq", 8'h00, {7'h0, irq});
        {t0, bgen} <= 2'b11;
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr_reg(`SCRX_A_CHAR, 8'h24 | 8'(k << 3));
            q_oe.push_back(8'(k == 3 ? 2 : k + 2));
            rx(d, 1'b1, 1'b1, d);
            rd_reg(`SCRX_A_STAT, 8'h01);
        end
        t0 <= 1'b0;
        rx(d, 1'b1, 1'b1, d);
        rd_reg(`SCRX_A_IRQ, 8'h01);
        rd_reg(`SCRX_A_STAT, 8'h01);
        rd_reg(`SCRX_A_STAT, 8'h00);
        wr_reg(`SCRX_A_IRQ, 8'h01);
        full <= 1'b1;
        rd_reg(`SCRX_A_STAT, 8'h08);
        rx(d, 1'b0, 1'b0, 8'h00);
        rd_reg(`SCRX_A_IRQ, 8'h02);
        full <= 1'b0;
        rx(d, 1'b0, 1'b0, 8'h00);
        rd_reg(`SCRX_A_STAT, 8'h02);
        rd_reg(`SCRX_A_STAT, 8'h00);
        rx(d, 1'b0, 1'b1, d);
        wr_reg(`SCRX_A_IRQ, 8'h02);
        wr_reg(`SCRX_A_CHAR, 8'h2c);
        rx(8'h03, 1'b0, 1'b1, 8'h03);
        rd_reg(`SCRX_A_CHAR, 8'h2c);
        pdis <= 1'b1;
        wr_reg(`SCRX_A_CHAR, 8'h6c);
        rx(8'h03, 1'b1, 1'b1, 8'h3f);
        rd_reg(`SCRX_A_STAT, 8'h00);
        rd_reg(`SCRX_A_CHAR, 8'h0c);
        e = ~d;
        e = {<<{e}};
        rx(d, 1'b0, 1'b1, e);
        wr_reg(`SCRX_A_CHAR, 8'h8c);
        rx(d, 1'b0, 1'b1, d);
        wr_reg(`SCRX_A_CHAR, 8'h2c);
        rx(d, 1'b0, 1'b1, d);
        pdis <= 1'b0;
        wr_reg(`SCRX_A_CHAR, 8'h4c);
        rx(8'h3b, 1'b0, 1'b1, 8'h3b);
        rd_reg(`SCRX_A_CHAR, 8'h2c);
        txs <= 1'b1;
        @(posedge clk);
        txs <= 1'b0;
        n = 0;
        fork
            i_card.brk();
            begin
                while (cbrk !== 1'b1 && n < 400) begin
                    @(negedge clk);
                    n++;
                end
                cmp("card_break", 8'h01, {7'h0, cbrk});
            end
        join
        sync <= 1'b1;
        for (int b = 1; b >= 0; b--) begin
            i_card.sync9(b[0]);
            rd_reg(`SCRX_A_STAT, {b[0], 7'h00});
        end
        sync <= 1'b0;
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : smart_card_rx_status_and_ts_control_tb
`default_nettype wire
